// ===== src/dds_regs.svh
`ifndef DDS_REGS_SVH
`define DDS_REGS_SVH

// register byte offsets
`define DDS_CTRL_OFS 8'h00
`define DDS_STATUS_OFS 8'h04
`define DDS_ISTAT_OFS 8'h08
`define DDS_IMASK_OFS 8'h0c

// control fields and reset values
`define DDS_CTRL_SEP_EN 0
`define DDS_CTRL_MOTOR_HOLD 1
`define DDS_CTRL_RST 32'h0000_0001
`define DDS_IMASK_RST 32'h0000_0000

// status fields
`define DDS_ST_READY 0
`define DDS_ST_TRUE_READY 1
`define DDS_ST_TWO_SIDED 2
`define DDS_ST_PROTECTED 3
`define DDS_ST_AT_SPEED 4
`define DDS_ST_SEEK_DONE 5
`define DDS_ST_DOOR 6
`define DDS_ST_MOTOR 7
`define DDS_ST_SECT_LO 8
`define DDS_ST_SECT_HI 13

// interrupt event bits
`define DDS_EV_READY 0
`define DDS_EV_TRUE_READY 1
`define DDS_EV_WR_BLOCK 2
`define DDS_EV_INDEX 3
`define DDS_EV_W 4

// pin vector positions
`define DDS_PIN_DOOR 0
`define DDS_PIN_TWO_SIDED 1
`define DDS_PIN_HARD_SECT 2
`define DDS_PIN_PROTECT 3
`define DDS_PIN_AT_SPEED 4
`define DDS_PIN_SEEK_DONE 5
`define DDS_PIN_INDEX 6
`define DDS_PIN_SECTOR 7
`define DDS_PIN_FLUX 8
`define DDS_PIN_SEL_N 9
`define DDS_PIN_SIDE1_N 10
`define DDS_PIN_WGATE_N 11
`define DDS_PIN_W 12

// hole counts and sector count
`define DDS_HOLES_ONE_SIDE 2
`define DDS_HOLES_TWO_SIDE 3
`define DDS_SECTORS 32

// timing in ns and derived cycle counts
`define DDS_CLK_NS 100
`define DDS_SECTOR_NS 400000
`define DDS_INDEX_NS 1800000
`define DDS_CELL_NS 4000
`define DDS_SECTOR_CYC ((`DDS_SECTOR_NS+`DDS_CLK_NS-1)/`DDS_CLK_NS)
`define DDS_INDEX_CYC ((`DDS_INDEX_NS+`DDS_CLK_NS-1)/`DDS_CLK_NS)
`define DDS_WIN_OPEN_CYC ((`DDS_CELL_NS/4+`DDS_CLK_NS-1)/`DDS_CLK_NS)
`define DDS_WIN_CLOSE_CYC ((`DDS_CELL_NS*3/4)/`DDS_CLK_NS)
`define DDS_LOSE_CYC ((`DDS_CELL_NS*2)/`DDS_CLK_NS)

`endif

// ===== src/dds_pkg.sv
package dds_pkg;
  typedef enum logic [1:0] {DDS_IDLE, DDS_SPIN, DDS_READY} dds_state_e;
  typedef logic [31:0] dds_word_t;
  typedef logic [15:0] dds_cnt_t;
  typedef logic [7:0] dds_cell_t;
endpackage

// ===== src/dds_sep_if.sv
`timescale 1ns/100ps
interface dds_sep_if;
  logic fluxPulse;
  logic enable;
  logic dataPulse;
  logic clockPulse;
  modport sep (input fluxPulse, input enable, output dataPulse,
               output clockPulse);
  modport host (output fluxPulse, output enable, input dataPulse,
                input clockPulse);
endinterface

// ===== src/dds_fm_sep.sv
`timescale 1ns/100ps
`include "dds_regs.svh"
module dds_fm_sep (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pulse stream in, separated pulses out
  dds_sep_if.sep sp
);
  import dds_pkg::*;

  dds_cell_t cellCnt_ff;
  logic locked_ff;
  logic dataPulse_ff;
  logic clockPulse_ff;
  logic inWindow;
  logic lateEdge;
  logic isClock;
  logic isData;
  logic lost;

  assign inWindow = (cellCnt_ff >= 8'(`DDS_WIN_OPEN_CYC)) &&
                    (cellCnt_ff < 8'(`DDS_WIN_CLOSE_CYC));
  assign lateEdge = cellCnt_ff >= 8'(`DDS_WIN_CLOSE_CYC);
  // fixed windows: early pulses before the data window are noise
  assign isClock = sp.enable && sp.fluxPulse && (!locked_ff || lateEdge);
  assign isData = sp.enable && sp.fluxPulse && locked_ff && inWindow;
  assign lost = !sp.enable || (cellCnt_ff >= 8'(`DDS_LOSE_CYC));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cellCnt_ff <= 8'h00;
      locked_ff <= 1'b0;
    end else if (isClock) begin
      cellCnt_ff <= 8'h00;
      locked_ff <= 1'b1;
    end else if (lost) begin
      cellCnt_ff <= 8'h00;
      locked_ff <= 1'b0;
    end else begin
      cellCnt_ff <= cellCnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dataPulse_ff <= 1'b0;
      clockPulse_ff <= 1'b0;
    end else begin
      dataPulse_ff <= isData;
      clockPulse_ff <= isClock;
    end
  end

  assign sp.dataPulse = dataPulse_ff;
  assign sp.clockPulse = clockPulse_ff;
endmodule

// ===== src/dds_drive_status.sv
// Notes on behaviour
// - sector mark for each of 32 holes
// - sector mark idles high, low 0.4 ms
// - ready after two holes, three two-sided
// - door closed spins motor until ready
// - single-sided: ready only on side 0
// - two-sided: ready on either side
// - read outputs need select, true ready, no write
// - raw flux pulses active low, idle high
// - separated data bits active low pulses
// - separated clock bits active low pulses
// - write-lock output low when protected
// - protected diskette blocks all writing
// - true ready needs speed, seek done, ready
// - one index mark per revolution at speed
// - only selected drive drives its outputs
// - clock at cell edge, data at centre
`timescale 1ns/100ps
`include "dds_regs.svh"
module dds_drive_status #(
  parameter int INDEX_PULSE_CYC = `DDS_INDEX_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire dds_pkg::dds_word_t pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mechanism sensors, asynchronous
  input wire logic doorClosed,
  input wire logic twoSidedDisk,
  input wire logic hardSectorDisk,
  input wire logic protectSense,
  input wire logic spindleAtSpeed,
  input wire logic seekDone,
  input wire logic indexHole,
  input wire logic sectorHole,
  input wire logic fluxPulse,
  // controller inputs, active low, asynchronous
  input wire logic unitSel_n,
  input wire logic sideOne_n,
  input wire logic writeGate_n,
  // controller outputs, active low
  output logic sectorMark_n,
  output logic revMark_n,
  output logic ready_n,
  output logic trueReady_n,
  output logic readData_n,
  output logic sepData_n,
  output logic sepClock_n,
  output logic writeLock_n,
  // mechanism controls
  output logic motorRun,
  output logic writeCurrentEn,
  // interrupt
  output logic irq
);
  import dds_pkg::*;

  localparam logic [`DDS_PIN_W-1:0] PIN_IDLE = 12'he00;

  logic [`DDS_PIN_W-1:0] pinRaw;
  logic [`DDS_PIN_W-1:0] sync1_ff;
  logic [`DDS_PIN_W-1:0] sync2_ff;
  logic [`DDS_PIN_W-1:0] prev_ff;
  dds_state_e state_ff;
  dds_state_e nxt_state;
  logic [1:0] holeCnt_ff;
  logic [1:0] nxt_holeCnt;
  dds_cnt_t sectCnt_ff;
  dds_cnt_t indexCnt_ff;
  logic [5:0] sectIdx_ff;
  logic [5:0] sectPerRev_ff;
  dds_word_t ctrl_ff;
  dds_word_t istat_ff;
  dds_word_t imask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic sectorMark_n_ff;
  logic revMark_n_ff;
  logic ready_n_ff;
  logic trueReady_n_ff;
  logic readData_n_ff;
  logic sepData_n_ff;
  logic sepClock_n_ff;
  logic writeLock_n_ff;
  logic motorRun_ff;
  logic writeCurrentEn_ff;
  logic irq_ff;
  logic readyOk_ff;
  logic trueReadyOk_ff;
  logic wrBlocked_ff;

  dds_sep_if sepBus ();

  assign pinRaw = {writeGate_n, sideOne_n, unitSel_n, fluxPulse,
                   sectorHole, indexHole, seekDone, spindleAtSpeed,
                   protectSense, hardSectorDisk, twoSidedDisk, doorClosed};

  // two-stage synchroniser per pin; stage one feeds only stage two
  genvar gi;
  generate
    for (gi = 0; gi < `DDS_PIN_W; gi++) begin : gSync
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          sync1_ff[gi] <= PIN_IDLE[gi];
          sync2_ff[gi] <= PIN_IDLE[gi];
          prev_ff[gi] <= PIN_IDLE[gi];
        end else begin
          sync1_ff[gi] <= pinRaw[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          prev_ff[gi] <= sync2_ff[gi];
        end
      end
    end
  endgenerate

  logic door;
  logic twoSided;
  logic hardSect;
  logic protect;
  logic atSpeed;
  logic seekOk;
  logic selected;
  logic sideZero;
  logic writeReq;
  logic indexEdge;
  logic sectorEdge;
  logic fluxEdge;
  logic [1:0] holesNeeded;
  logic readyQual;
  logic trueReadyQual;
  logic readGate;
  logic wrBlockEv;

  assign door = sync2_ff[`DDS_PIN_DOOR];
  assign twoSided = sync2_ff[`DDS_PIN_TWO_SIDED];
  assign hardSect = sync2_ff[`DDS_PIN_HARD_SECT];
  assign protect = sync2_ff[`DDS_PIN_PROTECT];
  assign atSpeed = sync2_ff[`DDS_PIN_AT_SPEED];
  assign seekOk = sync2_ff[`DDS_PIN_SEEK_DONE];
  assign selected = !sync2_ff[`DDS_PIN_SEL_N];
  assign sideZero = sync2_ff[`DDS_PIN_SIDE1_N];
  assign writeReq = !sync2_ff[`DDS_PIN_WGATE_N];
  assign indexEdge = sync2_ff[`DDS_PIN_INDEX] && !prev_ff[`DDS_PIN_INDEX];
  assign sectorEdge = sync2_ff[`DDS_PIN_SECTOR] && !prev_ff[`DDS_PIN_SECTOR];
  assign fluxEdge = sync2_ff[`DDS_PIN_FLUX] && !prev_ff[`DDS_PIN_FLUX];

  // ready sequencing
  assign holesNeeded = twoSided ? 2'(`DDS_HOLES_TWO_SIDE) :
                                  2'(`DDS_HOLES_ONE_SIDE);
  always_comb begin
    nxt_state = state_ff;
    nxt_holeCnt = holeCnt_ff;
    case (state_ff)
      DDS_IDLE: begin
        nxt_holeCnt = 2'h0;
        if (door) begin
          nxt_state = DDS_SPIN;
        end
      end
      DDS_SPIN: begin
        if (!door) begin
          nxt_state = DDS_IDLE;
        end else if (indexEdge) begin
          nxt_holeCnt = holeCnt_ff + 2'h1;
          if (holeCnt_ff + 2'h1 >= holesNeeded) begin
            nxt_state = DDS_READY;
          end
        end
      end
      DDS_READY: begin
        if (!door) begin
          nxt_state = DDS_IDLE;
        end
      end
      default: begin
        nxt_state = DDS_IDLE;
        nxt_holeCnt = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= DDS_IDLE;
      holeCnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      holeCnt_ff <= nxt_holeCnt;
    end
  end

  // side gating applies only to single-sided media
  assign readyQual = (state_ff == DDS_READY) &&
                     (twoSided || sideZero);
  assign trueReadyQual = readyQual && atSpeed && seekOk;
  assign readGate = selected && trueReadyOk_ff && !writeReq;
  assign wrBlockEv = selected && writeReq && protect;

  // pulse stretchers: restart on each hole, only at speed; sector ones only on hard-sectored media
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sectCnt_ff <= 16'h0000;
      indexCnt_ff <= 16'h0000;
    end else begin
      if (sectorEdge && hardSect && atSpeed) begin
        sectCnt_ff <= 16'(`DDS_SECTOR_CYC);
      end else if (sectCnt_ff != 16'h0000) begin
        sectCnt_ff <= sectCnt_ff - 16'h0001;
      end
      if (indexEdge && atSpeed) begin
        indexCnt_ff <= 16'(INDEX_PULSE_CYC);
      end else if (indexCnt_ff != 16'h0000) begin
        indexCnt_ff <= indexCnt_ff - 16'h0001;
      end
    end
  end

  // sector holes counted per revolution for software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sectIdx_ff <= 6'h00;
      sectPerRev_ff <= 6'h00;
    end else if (indexEdge) begin
      sectIdx_ff <= 6'h00;
      sectPerRev_ff <= sectIdx_ff;
    end else if (sectorEdge && hardSect && atSpeed &&
                 sectIdx_ff != 6'(`DDS_SECTORS)) begin
      sectIdx_ff <= sectIdx_ff + 6'h01;
    end
  end

  dds_fm_sep uSep (
    .clk(clk),
    .sys_rst(sys_rst),
    .sp(sepBus.sep)
  );
  assign sepBus.fluxPulse = fluxEdge;
  assign sepBus.enable = readGate && ctrl_ff[`DDS_CTRL_SEP_EN];

  // output stage; active-low outputs idle high while deselected
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readyOk_ff <= 1'b0;
      trueReadyOk_ff <= 1'b0;
      sectorMark_n_ff <= 1'b1;
      revMark_n_ff <= 1'b1;
      ready_n_ff <= 1'b1;
      trueReady_n_ff <= 1'b1;
      readData_n_ff <= 1'b1;
      sepData_n_ff <= 1'b1;
      sepClock_n_ff <= 1'b1;
      writeLock_n_ff <= 1'b1;
      motorRun_ff <= 1'b0;
      writeCurrentEn_ff <= 1'b0;
      wrBlocked_ff <= 1'b0;
    end else begin
      readyOk_ff <= readyQual;
      trueReadyOk_ff <= trueReadyQual;
      sectorMark_n_ff <= !(selected && sectCnt_ff != 16'h0000);
      revMark_n_ff <= !(selected && indexCnt_ff != 16'h0000);
      ready_n_ff <= !(selected && readyQual);
      trueReady_n_ff <= !(selected && trueReadyQual);
      readData_n_ff <= !(readGate && fluxEdge);
      sepData_n_ff <= !(readGate && sepBus.dataPulse);
      sepClock_n_ff <= !(readGate && sepBus.clockPulse);
      writeLock_n_ff <= !(selected && protect);
      // spindle runs by itself from door close until ready
      motorRun_ff <= door && (state_ff != DDS_READY || selected ||
                     ctrl_ff[`DDS_CTRL_MOTOR_HOLD]);
      writeCurrentEn_ff <= selected && writeReq && !protect;
      wrBlocked_ff <= wrBlockEv;
    end
  end

  // apb: no wait states, read data captured in the setup cycle
  logic isSetup;
  logic doWrite;
  logic selCtrl;
  logic selStatus;
  logic selIstat;
  logic selImask;
  logic mapped;
  logic [31:0] statusWord;
  logic [31:0] rdMux;
  logic [`DDS_EV_W-1:0] events;

  assign isSetup = psel && !penable;
  assign doWrite = psel && penable && pwrite && pready_ff && !pslverr_ff;
  assign selCtrl = paddr == `DDS_CTRL_OFS;
  assign selStatus = paddr == `DDS_STATUS_OFS;
  assign selIstat = paddr == `DDS_ISTAT_OFS;
  assign selImask = paddr == `DDS_IMASK_OFS;
  assign mapped = selCtrl || selStatus || selIstat || selImask;
  assign statusWord = {18'h0, sectPerRev_ff, motorRun_ff, door, seekOk,
                       atSpeed, protect, twoSided, trueReadyOk_ff,
                       readyOk_ff};
  assign rdMux = selCtrl ? ctrl_ff :
                 selStatus ? statusWord :
                 selIstat ? istat_ff :
                 selImask ? imask_ff : 32'h0000_0000;
  assign events = {indexEdge && atSpeed, wrBlockEv && !wrBlocked_ff,
                   trueReadyQual && !trueReadyOk_ff,
                   readyQual && !readyOk_ff};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= isSetup;
      pslverr_ff <= isSetup && !mapped;
      if (isSetup) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : rdMux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_ff <= `DDS_CTRL_RST;
      imask_ff <= `DDS_IMASK_RST;
    end else if (doWrite && selCtrl) begin
      ctrl_ff <= {30'h0, pwdata[1:0]};
    end else if (doWrite && selImask) begin
      imask_ff <= {28'h0, pwdata[`DDS_EV_W-1:0]};
    end
  end

  // a new event in the clear cycle survives the write-one-to-clear
  logic [`DDS_EV_W-1:0] clrMask;
  assign clrMask = (doWrite && selIstat) ? pwdata[`DDS_EV_W-1:0] : 4'h0;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      istat_ff <= 32'h0000_0000;
      irq_ff <= 1'b0;
    end else begin
      istat_ff <= {28'h0, (istat_ff[`DDS_EV_W-1:0] & ~clrMask) | events};
      irq_ff <= |(istat_ff[`DDS_EV_W-1:0] & imask_ff[`DDS_EV_W-1:0]);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign sectorMark_n = sectorMark_n_ff;
  assign revMark_n = revMark_n_ff;
  assign ready_n = ready_n_ff;
  assign trueReady_n = trueReady_n_ff;
  assign readData_n = readData_n_ff;
  assign sepData_n = sepData_n_ff;
  assign sepClock_n = sepClock_n_ff;
  assign writeLock_n = writeLock_n_ff;
  assign motorRun = motorRun_ff;
  assign writeCurrentEn = writeCurrentEn_ff;
  assign irq = irq_ff;
endmodule

// ===== sim/dds_status_assertions.sv
`timescale 1ns/100ps
module dds_status_assertions #(
  parameter int INDEX_PULSE_CYC = 18000
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // drive pins
  input wire logic unitSel_n,
  input wire logic sectorMark_n,
  input wire logic revMark_n,
  input wire logic ready_n,
  input wire logic trueReady_n,
  input wire logic readData_n,
  input wire logic sepData_n,
  input wire logic sepClock_n,
  input wire logic writeLock_n,
  input wire logic writeCurrentEn
);
  logic [15:0] secLow_ff;
  logic [15:0] revLow_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // mark widths are too long to unroll, so count them
  always_ff @(posedge clk) begin
    secLow_ff <= (sys_rst || sectorMark_n) ? 16'h0 : secLow_ff + 16'h1;
    revLow_ff <= (sys_rst || revMark_n) ? 16'h0 : revLow_ff + 16'h1;
  end
  sequence apbSetup;
    psel && !penable;
  endsequence
  sequence longIdle;
    unitSel_n [*6];
  endsequence
  apb_answer_a: assert property (apbSetup |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  err_in_access_a: assert property (pslverr |-> pready && penable)
    else $error("stray error flag");
  deselect_quiet_a: assert property (longIdle |=> ready_n && trueReady_n
    && readData_n && sepData_n && sepClock_n && writeLock_n
    && !writeCurrentEn) else $error("deselected drive active");
  true_needs_ready_a: assert property (!trueReady_n |-> !ready_n)
    else $error("true ready without ready");
  sep_apart_a: assert property (!sepData_n |-> sepClock_n)
    else $error("data and clock together");
  sector_width_a: assert property ($rose(sectorMark_n)
    |-> secLow_ff >= 16'h0fa0) else $error("sector mark short");
  index_width_a: assert property ($rose(revMark_n)
    |-> revLow_ff == 16'(INDEX_PULSE_CYC)) else $error("index width");
  lock_blocks_a: assert property (!writeLock_n |-> !writeCurrentEn)
    else $error("write on protected disk");
  read_gated_a: assert property (!readData_n |-> $past(!trueReady_n))
    else $error("read pulse ungated");
  raw_pulse_a: assert property ($fell(readData_n) |=> readData_n)
    else $error("raw pulse long");
endmodule

bind dds_drive_status dds_status_assertions #(
  .INDEX_PULSE_CYC(INDEX_PULSE_CYC)
) u_chk (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .unitSel_n(unitSel_n),
  .sectorMark_n(sectorMark_n), .revMark_n(revMark_n), .ready_n(ready_n),
  .trueReady_n(trueReady_n), .readData_n(readData_n),
  .sepData_n(sepData_n), .sepClock_n(sepClock_n),
  .writeLock_n(writeLock_n), .writeCurrentEn(writeCurrentEn));

// ===== sim/dds_ctl_model.sv
`timescale 1ns/100ps
module dds_ctl_model (
  // clock and commands
  input wire logic clk,
  input wire logic wantSel,
  input wire logic wantSide1,
  input wire logic wantWrite,
  input wire logic cntClr,
  // lines to the drive
  output logic unitSel_n = 1'b1,
  output logic sideOne_n = 1'b1,
  output logic writeGate_n = 1'b1,
  // lines from the drive
  input wire logic readData_n,
  input wire logic sepData_n,
  input wire logic sepClock_n,
  // pulses seen
  output logic [7:0] rawCnt = 8'h0,
  output logic [7:0] datCnt = 8'h0,
  output logic [7:0] clkCnt = 8'h0
);
  // lines move just after an edge, as a real controller's would
  always @(posedge clk) begin
    unitSel_n <= !wantSel;
    sideOne_n <= !wantSide1;
    writeGate_n <= !wantWrite;
  end
  // one low cycle is one pulse; no timers, it trusts true ready
  always @(posedge clk) begin
    rawCnt <= cntClr ? 8'h0 : rawCnt + 8'(!readData_n);
    datCnt <= cntClr ? 8'h0 : datCnt + 8'(!sepData_n);
    clkCnt <= cntClr ? 8'h0 : clkCnt + 8'(!sepClock_n);
  end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/100ps
module testbench;
  import dds_pkg::*;
  localparam int IDX = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  dds_word_t pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic door = 1'b0, two = 1'b0, hard = 1'b0, prot = 1'b0;
  logic spd = 1'b0, seek = 1'b0;
  logic [2:0] hole = 3'h0;
  logic wSel = 1'b0, wSide1 = 1'b0, wWr = 1'b0, cClr = 1'b0;
  logic selN, sideN, gateN, secN, revN, rdyN, trdyN, rdN, sdN, scN;
  logic wlN, motor, wcur, irq;
  logic [7:0] rawC, datC, clkC;
  int errCount = 0, checks = 0;

  always #50 clk = ~clk;

  dds_drive_status #(.INDEX_PULSE_CYC(IDX)) dut (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .doorClosed(door), .twoSidedDisk(two),
    .hardSectorDisk(hard), .protectSense(prot), .spindleAtSpeed(spd),
    .seekDone(seek), .indexHole(hole[0]), .sectorHole(hole[1]),
    .fluxPulse(hole[2]), .unitSel_n(selN), .sideOne_n(sideN),
    .writeGate_n(gateN), .sectorMark_n(secN), .revMark_n(revN),
    .ready_n(rdyN), .trueReady_n(trdyN), .readData_n(rdN),
    .sepData_n(sdN), .sepClock_n(scN), .writeLock_n(wlN),
    .motorRun(motor), .writeCurrentEn(wcur), .irq(irq));

  dds_ctl_model ctl (.clk(clk), .wantSel(wSel), .wantSide1(wSide1),
    .wantWrite(wWr), .cntClr(cClr), .unitSel_n(selN),
    .sideOne_n(sideN), .writeGate_n(gateN), .readData_n(rdN),
    .sepData_n(sdN), .sepClock_n(scN), .rawCnt(rawC), .datCnt(datC),
    .clkCnt(clkC));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, exp, input string m);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // no local limit: only the watchdog ends a stalled transfer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge, so back-to-back calls never assign psel twice at once
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, x, "read data");
    chk(e, xe, "error flag");
  endtask

  // holes and flux must stay up and down long enough for the synchroniser
  task automatic pulse(input int b);
    hole[b] <= 1'b1;
    cyc(3);
    hole[b] <= 1'b0;
    cyc(3);
  endtask

  task automatic flux;
    int g[5] = '{20, 20, 40, 20, 20};
    pulse(2);
    foreach (g[i]) begin
      cyc(g[i] - 6);
      pulse(2);
    end
  endtask

  task automatic width(input int b, output int w);
    int n;
    n = 0;
    w = 0;
    hole[b] <= 1'b1;
    cyc(3);
    hole[b] <= 1'b0;
    while ((b == 0 ? revN : secN) !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk);
    end
    while ((b == 0 ? revN : secN) === 1'b0 && w < 5000) begin
      w++;
      @(posedge clk);
    end
  endtask

  task automatic t_regs;
    rdchk(8'h00, 32'h1, 1'b0);
    rdchk(8'h0c, 32'h0, 1'b0);
    rdchk(8'h10, 32'h0, 1'b1);
    wr(8'h00, 32'h3);
    rdchk(8'h00, 32'h3, 1'b0);
    wr(8'h00, 32'h1);
    chk(rdyN, 1'b1, "ready at reset");
  endtask

  task automatic t_ready;
    wSel <= 1'b1;
    door <= 1'b1;
    cyc(8);
    chk(motor, 1'b1, "motor idle");
    pulse(0);
    cyc(8);
    chk(rdyN, 1'b1, "ready after one hole");
    pulse(0);
    cyc(8);
    chk(rdyN, 1'b0, "no ready");
    chk(irq, 1'b0, "masked irq");
    wr(8'h0c, 32'h1);
    cyc(2);
    chk(irq, 1'b1, "irq missing");
    wr(8'h08, 32'h1);
    cyc(2);
    chk(irq, 1'b0, "irq stuck");
    wSide1 <= 1'b1;
    cyc(8);
    chk(rdyN, 1'b1, "side 1 ready");
    door <= 1'b0;
    cyc(8);
    two <= 1'b1;
    door <= 1'b1;
    // holes before the synced door has left idle are not counted
    cyc(8);
    repeat (2) pulse(0);
    cyc(8);
    chk(rdyN, 1'b1, "two sided early");
    pulse(0);
    cyc(8);
    chk(rdyN, 1'b0, "two sided side 1");
    wSide1 <= 1'b0;
  endtask

  task automatic t_true;
    seek <= 1'b1;
    cyc(8);
    chk(trdyN, 1'b1, "true ready slow");
    spd <= 1'b1;
    cyc(8);
    chk(trdyN, 1'b0, "no true ready");
    seek <= 1'b0;
    cyc(8);
    chk(trdyN, 1'b1, "true ready seeking");
    seek <= 1'b1;
    cyc(8);
  endtask

  task automatic t_read;
    cClr <= 1'b1;
    cyc(1);
    cClr <= 1'b0;
    flux;
    cyc(10);
    chk(rawC, 8'h6, "raw count");
    chk(datC, 8'h2, "data count");
    chk(clkC, 8'h4, "clock count");
    wr(8'h00, 32'h0);
    cClr <= 1'b1;
    cyc(1);
    cClr <= 1'b0;
    flux;
    cyc(10);
    chk(rawC, 8'h6, "raw count unseparated");
    chk(datC + clkC, 8'h0, "separator disabled");
    wr(8'h00, 32'h1);
    wWr <= 1'b1;
    cClr <= 1'b1;
    cyc(1);
    cClr <= 1'b0;
    flux;
    cyc(10);
    chk(rawC, 8'h0, "read while writing");
    chk(wcur, 1'b1, "no write current");
    prot <= 1'b1;
    cyc(8);
    chk(wcur, 1'b0, "protected write");
    chk(wlN, 1'b0, "lock not shown");
    wSel <= 1'b0;
    cyc(8);
    chk(wlN, 1'b1, "lock while deselected");
    chk(motor, 1'b0, "motor after ready");
    wSel <= 1'b1;
    wWr <= 1'b0;
    prot <= 1'b0;
  endtask

  task automatic t_marks;
    int w;
    logic [31:0] r;
    logic e;
    hard <= 1'b1;
    cyc(8);
    width(0, w);
    chk(w, IDX, "index width");
    width(1, w);
    chk(w, 4000, "sector width");
    pulse(0);
    repeat (32) pulse(1);
    pulse(0);
    cyc(4);
    apb(8'h04, 1'b0, 32'h0, r, e);
    chk(r[13:8], 6'h20, "sector count");
    cyc(4100);
    hard <= 1'b0;
    pulse(1);
    cyc(8);
    chk(secN, 1'b1, "soft sector mark");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // the run needs some 9000 cycles
  initial begin
    cyc(40000);
    errCount++;
    $display("[ERR] %0t timeout", $time);
    tally_and_finish;
  end

  initial begin
    cyc(3);
    sys_rst <= 1'b0;
    cyc(1);
    t_regs;
    t_ready;
    t_true;
    t_read;
    t_marks;
    tally_and_finish;
  end
endmodule
